// ===== bench/tb_reset_release_sequencer.sv
// self-checking bench for the reset release sequencer, with a cycle model of the delays
`timescale 1ns/1ps
module tb_reset_release_sequencer;
    import rrs_pkg::*;
    // short counts so that a run stays small
    localparam int PU_CYC = 20;
    localparam int OSC_P = 4;
    // the pin clock is a little faster than 4 system cycles, so four periods fit in this
    localparam int OSC_CYC = OSC_P * 4;
    // latency of start pulse, counter load and synchronisers on top of the bare delays
    localparam int SLACK_RST = 6;
    localparam int SLACK_RUN = 12;
    localparam int LIMIT = 3000;

    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reset_event_in = 1'b0;
    logic [1:0] reset_cause_in = 2'h0;
    logic [2:0] clk_src_in = 3'h0;
    logic power_up_timer_en_in = 1'b0;
    logic two_speed_en_in = 1'b0;
    logic osc_clk_in = 1'b0;
    logic system_reset_out;
    logic system_clock_en_out;
    logic run_code_out;
    logic clock_fail_monitor_en_out;
    int seed = int'(32'h858a7950);
    int num_errors = 0;
    int comparisons = 0;
    int cases[$];

    rrs_sequencer #(.POWER_UP_CYC(PU_CYC), .OSC_PERIODS(OSC_P)) dut_u (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .reset_event_in(reset_event_in),
        .reset_cause_in(reset_cause_in),
        .clk_src_in(clk_src_in),
        .power_up_timer_en_in(power_up_timer_en_in),
        .two_speed_en_in(two_speed_en_in),
        .osc_clk_in(osc_clk_in),
        .system_reset_out(system_reset_out),
        .system_clock_en_out(system_clock_en_out),
        .run_code_out(run_code_out),
        .clock_fail_monitor_en_out(clock_fail_monitor_en_out)
    );

    always #50 sys_clk_in = ~sys_clk_in;
    // pin clock unrelated in phase to the system clock
    always #193 osc_clk_in = ~osc_clk_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic int hold_exp(input logic [1:0] cause, input logic pu);
        int pw;
        pw = pu ? PU_CYC : 0;
        if (cause == 2'h0) return POWER_ON_DELAY_CYC + pw;
        if (cause == 2'h1) return pw;
        return 0;
    endfunction

    function automatic int clk_exp(input logic [2:0] src, input logic [1:0] cause, input logic ts);
        if (cause > 2'h1) return 0;
        if (ts) return FAST_RC_CYC;
        case (src)
            3'h1: return FAST_RC_CYC + PLL_LOCK_CYC;
            3'h2, 3'h4: return OSC_CYC;
            3'h3: return OSC_CYC + PLL_LOCK_CYC;
            3'h5: return LOW_POWER_RC_CYC;
            default: return FAST_RC_CYC;
        endcase
    endfunction

    // one device reset: event, then measure when the reset, run and monitor outputs settle
    task automatic run_case(input logic [1:0] cause, input logic [2:0] src, input logic ts);
        int n;
        int r;
        int t_rst;
        int t_run;
        int t_mon;
        int h;
        int m;
        r = $random(seed);
        t_rst = -1;
        t_run = -1;
        t_mon = -1;
        @(posedge sys_clk_in);
        #10;
        reset_cause_in = cause;
        clk_src_in = src;
        two_speed_en_in = ts;
        power_up_timer_en_in = r[0];
        reset_event_in = 1'b1;
        h = hold_exp(cause, r[0]);
        m = clk_exp(src, cause, ts);
        // delays overlap, so the later one decides
        m = (h > m) ? h : m;
        @(posedge sys_clk_in);
        #10;
        reset_event_in = 1'b0;
        for (n = 1; n < LIMIT && (t_run < 0 || t_mon < 0); n++) begin
            @(negedge sys_clk_in);
            if (t_rst < 0 && system_reset_out === 1'b0) t_rst = n;
            if (t_run < 0 && run_code_out === 1'b1) t_run = n;
            if (t_rst >= 0 && t_mon < 0 && clock_fail_monitor_en_out === 1'b1) t_mon = n;
        end
        check(t_rst >= h && t_rst <= h + SLACK_RST, 1'b1);
        check(t_run >= m && t_run <= m + SLACK_RUN, 1'b1);
        check(t_mon - t_rst >= FAIL_MON_CYC - 2 && t_mon - t_rst <= FAIL_MON_CYC + 4, 1'b1);
        $display("case cause=%0d src=%0d two_speed=%0d pu=%0d rst=%0d run=%0d mon=%0d",
            cause, src, ts, r[0], t_rst, t_run, t_mon);
    endtask

    // standing relations between the outputs, looked at every cycle while rst_n_in is high
    always @(negedge sys_clk_in) begin
        if (rst_n_in) begin
            check(system_clock_en_out, run_code_out);
            check(run_code_out & system_reset_out, 1'b0);
            check(clock_fail_monitor_en_out & system_reset_out, 1'b0);
        end
    end

    initial begin
        #(60000 * 100);
        num_errors++;
        $display("BAD at %0t: run did not finish in time", $time);
        wrap_up();
    end

    initial begin
        int c;
        int s;
        for (c = 0; c < 4; c++) begin
            for (s = 0; s < 8; s++) begin
                cases.push_back(c * 16 + s);
            end
        end
        // two-speed start only on sources without a lock wait
        for (c = 0; c < 3; c++) begin
            cases.push_back(c * 16 + 8 + 2);
            cases.push_back(c * 16 + 8 + 4);
            cases.push_back(c * 16 + 8 + 5);
        end
        repeat (2) @(posedge sys_clk_in);
        #10;
        rst_n_in = 1'b1;
        while (cases.size() > 0) begin
            c = cases.pop_front();
            run_case(2'(c / 16), 3'(c % 8), 1'((c / 8) % 2));
        end
        // reset in the middle of a hold must fall back to idle
        @(posedge sys_clk_in);
        #10;
        reset_cause_in = 2'h0;
        clk_src_in = 3'h3;
        two_speed_en_in = 1'b0;
        reset_event_in = 1'b1;
        @(posedge sys_clk_in);
        #10;
        reset_event_in = 1'b0;
        repeat (20) @(posedge sys_clk_in);
        #10;
        rst_n_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #10;
        check(system_reset_out, 1'b1);
        check(run_code_out, 1'b0);
        check(clock_fail_monitor_en_out, 1'b0);
        rst_n_in = 1'b1;
        $display("case mid-hold reset done");
        run_case(2'h1, 3'h2, 1'b0);
        wrap_up();
    end
endmodule

// ===== core/rrs_down_counter.sv
// one-shot down counter: loads on start, done level held high once it reaches zero
`timescale 1ns/1ps
module rrs_down_counter
    import rrs_pkg::*;
#(
    parameter int W = 24
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // control
    input wire logic start_in,
    input wire logic [W-1:0] load_in,
    input wire logic tick_in,
    // status
    output logic done_out
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic run_reg;
    logic run_next;
    logic done_reg;
    logic done_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        done_next = done_reg;
        if (start_in) begin
            cnt_next = load_in;
            run_next = (load_in != '0);
            done_next = (load_in == '0);
        end else if (run_reg && tick_in) begin
            if (cnt_reg <= W'(1)) begin
                cnt_next = '0;
                run_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            done_reg <= done_next;
        end
    end

    assign done_out = done_reg;
endmodule

// ===== core/rrs_sequencer.sv
// reset release sequencer: holds system reset and system clock after a device reset
// Summary of operation
// - power-on: hold system reset for power-on delay plus power-up delay
// - power-up delay is 64 ms when timer enabled, else zero
// - crystal and secondary sources: 24-bit counter waits 1024 oscillator periods
// - oscillator and RC counts run alongside the reset hold, PLL lock starts after them
// - execution starts only when reset released and clock delays complete
// - PLL sources wait for PLL lock after oscillator start-up
// - RC sources wait RC start-up, plus PLL lock for fast RC with PLL
// - clock fail monitor starts after reset release and its own delay
// - two-speed start-up runs from fast RC with its start-up delay
`timescale 1ns/1ps
module rrs_sequencer
    import rrs_pkg::*;
#(
    parameter int POWER_UP_CYC = POWER_UP_DELAY_CYC,
    parameter int OSC_PERIODS = OSC_STARTUP_PERIODS
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // reset event and configuration
    input wire logic reset_event_in,
    input wire logic [1:0] reset_cause_in,
    input wire logic [2:0] clk_src_in,
    input wire logic power_up_timer_en_in,
    input wire logic two_speed_en_in,
    // oscillator clock from the pin, sampled as a level
    input wire logic osc_clk_in,
    // outputs
    output logic system_reset_out,
    output logic system_clock_en_out,
    output logic run_code_out,
    output logic clock_fail_monitor_en_out
);
    typedef enum logic [1:0] {
        RRS_ST_IDLE = 2'b00,
        RRS_ST_HOLD = 2'b01,
        RRS_ST_RUN  = 2'b10
    } rrs_state_t;

    rrs_state_t state_reg;
    rrs_state_t state_next;
    logic start_reg;
    logic start_next;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic osc_tick;
    logic cause_por;
    logic cause_brown_out;
    logic use_osc;
    logic use_pll;
    logic use_fast_rc;
    logic use_low_power_rc;
    logic [CNT_W-1:0] rst_load;
    logic [CNT_W-1:0] rc_load;
    logic [CNT_W-1:0] pll_load;
    logic [CNT_W-1:0] osc_load;
    logic [CNT_W-1:0] fm_load;
    logic rst_done;
    logic rc_done;
    logic osc_done;
    logic pll_done;
    logic fm_done;
    logic pll_start_reg;
    logic pll_start_next;
    logic pll_go_reg;
    logic pll_go_next;
    logic fm_start_reg;
    logic fm_start_next;
    logic fm_armed_reg;
    logic fm_armed_next;
    logic src_ready;
    logic [CNT_W-1:0] zero;

    assign zero = '0;

    // oscillator pin through two flops, third flop only for edge detection
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_clk_in;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end
    assign osc_tick = osc_s2_reg && !osc_s3_reg;

    // source decode; two-speed start forces fast RC
    always_comb begin
        cause_por = (reset_cause_in == RRS_CAUSE_POR);
        cause_brown_out = (reset_cause_in == RRS_CAUSE_BROWN_OUT);
        use_osc = 1'b0;
        use_pll = 1'b0;
        use_fast_rc = 1'b0;
        use_low_power_rc = 1'b0;
        if (two_speed_en_in) begin
            use_fast_rc = 1'b1;
        end else begin
            case (rrs_src_t'(clk_src_in))
                RRS_SRC_FAST_RC, RRS_SRC_FAST_RC_DIV, RRS_SRC_LOW_POWER_FAST_RC_DIV: begin
                    use_fast_rc = 1'b1;
                end
                RRS_SRC_FAST_RC_PLL: begin
                    use_fast_rc = 1'b1;
                    use_pll = 1'b1;
                end
                RRS_SRC_LOW_POWER_RC: use_low_power_rc = 1'b1;
                RRS_SRC_SECONDARY: use_osc = 1'b1;
                // primary source counted as a crystal; an external clock still gets
                // the oscillator count, a conservative trade for lack of a mode input
                RRS_SRC_PRI: use_osc = 1'b1;
                RRS_SRC_PRI_PLL: begin
                    use_osc = 1'b1;
                    use_pll = 1'b1;
                end
                default: use_fast_rc = 1'b1;
            endcase
        end
        if (!(cause_por || cause_brown_out)) begin
            use_osc = 1'b0;
            use_pll = 1'b0;
            use_fast_rc = 1'b0;
            use_low_power_rc = 1'b0;
        end
    end

    // reset hold load
    always_comb begin
        rst_load = '0;
        if (cause_por) begin
            rst_load = CNT_W'(POWER_ON_DELAY_CYC);
        end
        if ((cause_por || cause_brown_out) && power_up_timer_en_in) begin
            rst_load = rst_load + CNT_W'(POWER_UP_CYC);
        end
        rc_load = use_fast_rc ? CNT_W'(FAST_RC_CYC)
                  : (use_low_power_rc ? CNT_W'(LOW_POWER_RC_CYC) : '0);
        osc_load = use_osc ? CNT_W'(OSC_PERIODS) : '0;
        pll_load = use_pll ? CNT_W'(PLL_LOCK_CYC) : '0;
        fm_load = CNT_W'(FAIL_MON_CYC);
    end

    // RC and oscillator delays start with the reset hold; pll lock starts later
    rrs_down_counter #(.W(CNT_W)) u_rst_cnt (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_reg),
        .load_in(rst_load), .tick_in(1'b1), .done_out(rst_done));
    rrs_down_counter #(.W(CNT_W)) u_rc_cnt (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_reg),
        .load_in(rc_load), .tick_in(1'b1), .done_out(rc_done));
    rrs_down_counter #(.W(CNT_W)) u_osc_cnt (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(start_reg),
        .load_in(osc_load), .tick_in(osc_tick), .done_out(osc_done));
    // pll lock counted after its reference oscillator is up
    rrs_down_counter #(.W(CNT_W)) u_pll_cnt (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(pll_start_reg),
        .load_in(pll_load), .tick_in(1'b1), .done_out(pll_done));
    rrs_down_counter #(.W(CNT_W)) u_fm_cnt (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .start_in(fm_start_reg),
        .load_in(fm_load), .tick_in(1'b1), .done_out(fm_done));

    assign src_ready = rc_done && osc_done && pll_go_reg && pll_done;

    always_comb begin
        state_next = state_reg;
        start_next = 1'b0;
        pll_start_next = 1'b0;
        pll_go_next = pll_go_reg;
        fm_start_next = 1'b0;
        fm_armed_next = fm_armed_reg;
        case (state_reg)
            RRS_ST_IDLE: begin
                if (reset_event_in) begin
                    start_next = 1'b1;
                    pll_go_next = 1'b0;
                    fm_armed_next = 1'b0;
                    state_next = RRS_ST_HOLD;
                end
            end
            RRS_ST_HOLD: begin
                if (!start_reg && !pll_go_reg && rc_done && osc_done) begin
                    pll_start_next = 1'b1;
                    pll_go_next = 1'b1;
                end
                if (!start_reg && rst_done && !fm_armed_reg) begin
                    fm_start_next = 1'b1;
                    fm_armed_next = 1'b1;
                end
                if (!start_reg && !pll_start_reg && rst_done && src_ready) begin
                    state_next = RRS_ST_RUN;
                end
            end
            RRS_ST_RUN: begin
                if (reset_event_in) begin
                    start_next = 1'b1;
                    pll_go_next = 1'b0;
                    fm_armed_next = 1'b0;
                    state_next = RRS_ST_HOLD;
                end
            end
            default: state_next = RRS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_reg <= RRS_ST_IDLE;
            start_reg <= 1'b0;
            pll_start_reg <= 1'b0;
            pll_go_reg <= 1'b0;
            fm_start_reg <= 1'b0;
            fm_armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            start_reg <= start_next;
            pll_start_reg <= pll_start_next;
            pll_go_reg <= pll_go_next;
            fm_start_reg <= fm_start_next;
            fm_armed_reg <= fm_armed_next;
        end
    end

    // reset held until the hold counter finishes
    assign system_reset_out = (state_reg != RRS_ST_HOLD) ? (state_reg == RRS_ST_IDLE)
                              : (start_reg || !rst_done);
    assign system_clock_en_out = (state_reg == RRS_ST_RUN);
    assign run_code_out = (state_reg == RRS_ST_RUN);
    assign clock_fail_monitor_en_out = fm_armed_reg && !fm_start_reg && fm_done;

    AST_RUN_NEEDS_ALL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(run_code_out) |-> rst_done && rc_done && osc_done && pll_done)
        else $error("code run before delays finished");
    AST_FM_AFTER_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        clock_fail_monitor_en_out |-> !system_reset_out)
        else $error("fail monitor active during system reset");
    AST_NO_RUN_IN_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        run_code_out |-> !system_reset_out)
        else $error("running while reset held");
    // taken from idle or run, so every other-cause event outside hold is watched while the cause stays other for six cycles
    AST_OTHER_FAST: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg != RRS_ST_HOLD && reset_event_in && reset_cause_in == RRS_CAUSE_OTHER)
        ##1 (reset_cause_in == RRS_CAUSE_OTHER)[*6] |-> run_code_out)
        else $error("other reset added delay");
    AST_POR_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg != RRS_ST_HOLD && reset_event_in && reset_cause_in == RRS_CAUSE_POR)
        |=> system_reset_out[*8])
        else $error("power-on reset released too early");
    AST_PLL_AFTER_OSC: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        pll_start_reg |-> rc_done && osc_done)
        else $error("pll wait started before oscillator ready");
    AST_BROWN_OUT_NO_TIMER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg != RRS_ST_HOLD && reset_event_in && reset_cause_in == RRS_CAUSE_BROWN_OUT
         && !power_up_timer_en_in) ##1 (reset_cause_in == RRS_CAUSE_BROWN_OUT)[*3] |->
        !system_reset_out)
        else $error("brown-out hold without timer");
    // done flags still hold the last run's value at the start pulse, so look one edge later
    AST_HOLD_TOGETHER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        start_reg |=> (rst_done == ($past(rst_load) == zero))
            && (rc_done == ($past(rc_load) == zero))
            && (osc_done == ($past(osc_load) == zero)))
        else $error("source delay not started with hold");

    COV_POR: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(run_code_out) && reset_cause_in == RRS_CAUSE_POR);
    COV_BROWN_OUT: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(run_code_out) && reset_cause_in == RRS_CAUSE_BROWN_OUT);
    COV_PLL: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in) pll_start_reg);
    COV_FM: cover property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        $rose(clock_fail_monitor_en_out));
endmodule

// ===== include/rrs_pkg.sv
// package: clock-source codes, reset causes, delay constants for the reset release sequencer
package rrs_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int CLK_PERIOD_NS = 100;
    // delays in their own units, figures as printed
    localparam int POWER_ON_DELAY_US = 5;
    localparam int POWER_UP_DELAY_MS = 64;
    localparam int PLL_LOCK_TIME_US = 100;
    localparam int FAST_RC_STARTUP_TIME_US = 1;
    localparam int LOW_POWER_RC_STARTUP_TIME_US = 1;
    localparam int FAIL_MONITOR_START_US = 1;
    localparam int OSC_STARTUP_PERIODS = 1024;
    localparam int OSC_CNT_W = 10;
    // cycle counts, least times rounded up, never below one
    localparam int POWER_ON_DELAY_CYC =
        (POWER_ON_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_DELAY_CYC = (POWER_UP_DELAY_MS * (CLK_HZ / 1000));
    localparam int PLL_LOCK_CYC = (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_RC_CYC =
        (FAST_RC_STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_POWER_RC_CYC =
        (LOW_POWER_RC_STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAIL_MON_CYC =
        (FAIL_MONITOR_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    // clock source selection codes
    typedef enum logic [2:0] {
        RRS_SRC_FAST_RC = 3'h0,
        RRS_SRC_FAST_RC_PLL = 3'h1,
        RRS_SRC_PRI = 3'h2,
        RRS_SRC_PRI_PLL = 3'h3,
        RRS_SRC_SECONDARY = 3'h4,
        RRS_SRC_LOW_POWER_RC = 3'h5,
        RRS_SRC_LOW_POWER_FAST_RC_DIV = 3'h6,
        RRS_SRC_FAST_RC_DIV = 3'h7
    } rrs_src_t;
    // reset cause codes
    typedef enum logic [1:0] {
        RRS_CAUSE_POR = 2'h0,
        RRS_CAUSE_BROWN_OUT = 2'h1,
        RRS_CAUSE_OTHER = 2'h2
    } rrs_cause_t;
endpackage
